// ==== tms_scan_seq.sv ====
`timescale 1ns/10ps
module tms_scan_seq #(
  parameter int KEY_CAP = tms_pkg::CAP_LARGE
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cmp_in,
  output logic [7:0] x_drive_reg,
  output logic [5:0] y_sel_reg,
  output logic ramp_en_reg,
  output logic alert_reg
);
  // Keys enabled out of reset
  localparam int DEF_KEYS = (KEY_CAP == tms_pkg::CAP_SMALL) ?
    tms_pkg::DEF_Y_LINES * tms_pkg::NUM_X : tms_pkg::NUM_KEYS;
  localparam logic [6:0] CAP7 = 7'(KEY_CAP);

  // Bus channel state
  logic aw_hold_reg, w_hold_reg, ar_hold_reg, rd_wait_reg;
  logic [11:0] awaddr_reg, araddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  // Control and status
  logic run_reg;
  logic [11:0] thresh_reg;
  logic [1:0] err_reg;
  logic [47:0] en_reg;        // Per-key enable, mirrors detect != 0
  logic [47:0] key_state_reg; // Per-key touch state
  logic [7:0] scan_count_reg;
  // Sequencer
  tms_pkg::tms_state_t seq_state;
  logic [5:0] key_reg;
  logic [5:0] next_key;
  logic any_en;
  logic [6:0] en_count;
  logic en_pick_reg;
  tms_pkg::tms_setting_t set_rd, set_cur_reg;
  tms_pkg::tms_result_t res_rd, res_new;
  logic [3:0] integ_reg;
  // Pins and pacing
  logic cmp_meta_reg, cmp_sync_reg;
  logic [4:0] div_reg;
  logic pulse_tick;
  // Engine handshake
  logic eng_start_reg, eng_drive, eng_ramp, eng_done, eng_tmo;
  logic [11:0] eng_value;
  // Decode of the write and read in progress, and of result updates
  logic wr_do, wr_setup, wr_refuse, setup_ok;
  logic [5:0] wr_key, rd_key;
  tms_pkg::tms_setting_t wr_set;
  logic status_rd, res_wr, key_chg;
  logic [5:0] res_rd_addr;

  assign wr_do = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign wr_key = awaddr_reg[7:2];
  assign wr_set = tms_pkg::tms_setting_t'(wdata_reg[11:0]);
  assign wr_setup = awaddr_reg[11:8] == tms_pkg::PAGE_SETUP &&
                    wr_key <= tms_pkg::LAST_KEY;
  // Enabling one more key at full capacity is refused
  assign wr_refuse = wr_setup && wr_set.detect != 4'h0 &&
                     !en_reg[wr_key] && en_count >= CAP7;
  assign setup_ok = wr_do && wr_setup && !wr_refuse;
  assign rd_key = araddr_reg[7:2];

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_hold_reg <= 1'b0;
      awaddr_reg <= 12'h000;
    end else begin
      s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_hold_reg;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_hold_reg <= 1'b0;
      end
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_hold_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      s_axi_wready <= s_axi_wvalid && !s_axi_wready && !w_hold_reg;
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (wr_do) begin
        w_hold_reg <= 1'b0;
      end
    end
  end

  // Write response: one answer per write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tms_pkg::RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      if (wr_refuse) begin
        s_axi_bresp <= tms_pkg::RESP_SLVERR;
      end else if (wr_setup || awaddr_reg == tms_pkg::ADDR_CTRL ||
                   awaddr_reg == tms_pkg::ADDR_THRESH ||
                   awaddr_reg == tms_pkg::ADDR_ERROR) begin
        s_axi_bresp <= tms_pkg::RESP_OKAY;
      end else begin
        s_axi_bresp <= tms_pkg::RESP_DECERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Software-written control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_reg <= 1'b0;
      thresh_reg <= tms_pkg::DEF_THRESH;
    end else if (wr_do) begin
      if (awaddr_reg == tms_pkg::ADDR_CTRL && wstrb_reg[0]) begin
        run_reg <= wdata_reg[tms_pkg::CTRL_RUN_BIT];
      end
      if (awaddr_reg == tms_pkg::ADDR_THRESH) begin
        if (wstrb_reg[0]) begin
          thresh_reg[7:0] <= wdata_reg[7:0];
        end
        if (wstrb_reg[1]) begin
          thresh_reg[11:8] <= wdata_reg[11:8];
        end
      end
    end
  end

  // Key enables follow the detect count written to each key
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < tms_pkg::NUM_KEYS; i++) begin
        en_reg[i] <= (i < DEF_KEYS);
      end
    end else if (setup_ok) begin
      en_reg[wr_key] <= wr_set.detect != 4'h0;
    end
  end

  // Count of enabled keys
  always_comb begin
    en_count = 7'h00;
    for (int i = 0; i < tms_pkg::NUM_KEYS; i++) begin
      en_count = en_count + {6'h00, en_reg[i]};
    end
  end

  // Next enabled key after the current one, wrapping past the last
  always_comb begin
    int idx;
    idx = 0;
    next_key = key_reg;
    any_en = 1'b0;
    for (int off = tms_pkg::NUM_KEYS; off >= 1; off--) begin
      idx = int'(key_reg) + off;
      if (idx >= tms_pkg::NUM_KEYS) begin
        idx = idx - tms_pkg::NUM_KEYS;
      end
      if (en_reg[idx]) begin
        next_key = 6'(idx);
        any_en = 1'b1;
      end
    end
  end

  // Error flags: hardware set wins over write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_reg <= 2'h0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if ((b == tms_pkg::ERR_CAP_BIT && wr_do && wr_refuse) ||
            (b == tms_pkg::ERR_CONV_BIT && eng_done && eng_tmo)) begin
          err_reg[b] <= 1'b1;
        end else if (wr_do && awaddr_reg == tms_pkg::ADDR_ERROR &&
                     wstrb_reg[0] && wdata_reg[b]) begin
          err_reg[b] <= 1'b0;
        end
      end
    end
  end

  // Comparator pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_meta_reg <= 1'b0;
      cmp_sync_reg <= 1'b0;
    end else begin
      cmp_meta_reg <= cmp_in;
      cmp_sync_reg <= cmp_meta_reg;
    end
  end

  // Acquisition pulse pacing
  assign pulse_tick = div_reg == 5'(tms_pkg::PULSE_CYC - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn || pulse_tick) begin
      div_reg <= 5'h00;
    end else begin
      div_reg <= div_reg + 5'h01;
    end
  end

  // Per-key setups: written by the bus, read by the sequencer
  tms_key_mem #(
    .W(12),
    .DEF_WORD({tms_pkg::DEF_DETECT, tms_pkg::DEF_BURST}),
    .DEF_COUNT(DEF_KEYS)
  ) u_setup (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(setup_ok),
    .wr_addr(wr_key),
    .wr_data(wdata_reg[11:0]),
    .rd_addr(key_reg),
    .rd_data(set_rd)
  );

  // Per-key results: written by the sequencer, shared read port
  assign res_rd_addr = (seq_state == tms_pkg::ST_LOAD) ? key_reg : rd_key;
  tms_key_mem #(
    .W(16),
    .DEF_WORD(16'h0000),
    .DEF_COUNT(0)
  ) u_result (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(res_wr),
    .wr_addr(key_reg),
    .wr_data(res_new),
    .rd_addr(res_rd_addr),
    .rd_data(res_rd)
  );

  // Burst and conversion of the current key
  tms_burst_engine u_eng (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(eng_start_reg),
    .burst_len(set_cur_reg.burst),
    .pulse_tick(pulse_tick),
    .cmp_sync(cmp_sync_reg),
    .drive_reg(eng_drive),
    .ramp_reg(eng_ramp),
    .done_reg(eng_done),
    .value_reg(eng_value),
    .timeout_reg(eng_tmo)
  );

  // Processing: low signal counts as a touch sample, integrated
  assign res_wr = seq_state == tms_pkg::ST_BURST && eng_done;
  always_comb begin
    res_new.signal = eng_value;
    res_new.integ = 4'h0;
    if (!eng_tmo && eng_value < thresh_reg) begin
      res_new.integ = (integ_reg < set_cur_reg.detect) ?
        integ_reg + 4'h1 : integ_reg;
    end
  end
  assign key_chg = res_wr &&
    key_state_reg[key_reg] != (res_new.integ >= set_cur_reg.detect);

  // Scan sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_state <= tms_pkg::ST_IDLE;
      key_reg <= tms_pkg::LAST_KEY;
      set_cur_reg <= '0;
      integ_reg <= 4'h0;
      eng_start_reg <= 1'b0;
      scan_count_reg <= 8'h00;
      en_pick_reg <= 1'b0;
    end else begin
      eng_start_reg <= 1'b0;
      unique case (seq_state)
        // Parked at the last key so the first pick is the lowest enabled key
        tms_pkg::ST_IDLE: begin
          key_reg <= tms_pkg::LAST_KEY;
          if (run_reg) begin
            seq_state <= tms_pkg::ST_FIND;
          end
        end
        tms_pkg::ST_FIND: begin
          if (!run_reg) begin
            seq_state <= tms_pkg::ST_IDLE;
          end else if (any_en) begin
            key_reg <= next_key;
            en_pick_reg <= en_reg[next_key];
            if (next_key <= key_reg) begin
              scan_count_reg <= scan_count_reg + 8'h01;
            end
            seq_state <= tms_pkg::ST_LOAD;
          end
        end
        // Memories read the current key this cycle
        tms_pkg::ST_LOAD: begin
          seq_state <= tms_pkg::ST_START;
        end
        tms_pkg::ST_START: begin
          set_cur_reg <= set_rd;
          integ_reg <= res_rd.integ;
          eng_start_reg <= 1'b1;
          seq_state <= tms_pkg::ST_BURST;
        end
        // Wait for the whole burst and conversion to finish
        tms_pkg::ST_BURST: begin
          if (eng_done) begin
            seq_state <= tms_pkg::ST_FIND;
          end
        end
      endcase
    end
  end

  // Touch states and alert; a status read clears alert, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_state_reg <= 48'h0;
      alert_reg <= 1'b0;
    end else begin
      if (res_wr) begin
        key_state_reg[key_reg] <= res_new.integ >= set_cur_reg.detect;
      end
      if (key_chg) begin
        alert_reg <= 1'b1;
      end else if (status_rd) begin
        alert_reg <= 1'b0;
      end
    end
  end

  // Matrix pins: drive line and receive line of the current key
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      x_drive_reg <= 8'h00;
      y_sel_reg <= 6'h00;
      ramp_en_reg <= 1'b0;
    end else begin
      x_drive_reg <= eng_drive ? 8'h01 << key_reg[2:0] : 8'h00;
      y_sel_reg <= (seq_state == tms_pkg::ST_BURST) ?
        6'h01 << key_reg[5:3] : 6'h00;
      ramp_en_reg <= eng_ramp;
    end
  end

  // Read address channel and two-cycle read
  assign status_rd = rd_wait_reg && araddr_reg == tms_pkg::ADDR_STATUS;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      ar_hold_reg <= 1'b0;
      araddr_reg <= 12'h000;
      rd_wait_reg <= 1'b0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !ar_hold_reg;
      if (s_axi_arvalid && s_axi_arready) begin
        ar_hold_reg <= 1'b1;
        araddr_reg <= s_axi_araddr;
      end else if (rd_wait_reg) begin
        ar_hold_reg <= 1'b0;
      end
      rd_wait_reg <= ar_hold_reg && !rd_wait_reg && !s_axi_rvalid &&
                     seq_state != tms_pkg::ST_LOAD;
    end
  end

  // Read data: result words and status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= tms_pkg::RESP_OKAY;
    end else if (rd_wait_reg) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= tms_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      if (araddr_reg[11:8] == tms_pkg::PAGE_RESULT &&
          rd_key <= tms_pkg::LAST_KEY) begin
        s_axi_rdata[15:0] <= res_rd;
      end else if (araddr_reg[11:8] == tms_pkg::PAGE_SETUP &&
                   rd_key <= tms_pkg::LAST_KEY) begin
        s_axi_rdata[0] <= en_reg[rd_key];
      end else begin
        unique case (araddr_reg)
          tms_pkg::ADDR_CTRL:
            s_axi_rdata[tms_pkg::CTRL_RUN_BIT] <= run_reg;
          tms_pkg::ADDR_STATUS: begin
            s_axi_rdata[tms_pkg::ST_CNT_LSB +: 7] <= en_count;
            s_axi_rdata[tms_pkg::ST_KEY_LSB +: 6] <= key_reg;
            s_axi_rdata[tms_pkg::ST_ALERT_BIT] <= alert_reg;
            s_axi_rdata[tms_pkg::ST_SCAN_LSB +: 8] <= scan_count_reg;
          end
          tms_pkg::ADDR_THRESH: s_axi_rdata[11:0] <= thresh_reg;
          tms_pkg::ADDR_KEYS_LO: s_axi_rdata <= key_state_reg[31:0];
          tms_pkg::ADDR_KEYS_HI: s_axi_rdata[15:0] <= key_state_reg[47:32];
          tms_pkg::ADDR_ERROR: s_axi_rdata[1:0] <= err_reg;
          default: s_axi_rresp <= tms_pkg::RESP_DECERR;
        endcase
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_scan_start;
    seq_state == tms_pkg::ST_IDLE && run_reg
    ##1 seq_state == tms_pkg::ST_FIND && run_reg && en_reg[0];
  endsequence

  a_drive_line_map: assert property (
    x_drive_reg != 8'h00 |-> x_drive_reg == 8'h01 << key_reg[2:0] &&
    y_sel_reg == 6'h01 << key_reg[5:3])
    else $error("drive or receive line does not match key");
  a_cap_limit: assert property (en_count <= CAP7)
    else $error("enabled keys exceed capacity");
  a_small_defaults: assert property (
    $past(!aresetn) && KEY_CAP == tms_pkg::CAP_SMALL |->
    en_reg[47:32] == 16'h0000 && en_reg[31:0] == 32'hFFFF_FFFF)
    else $error("wrong default key set");
  a_pick_enabled: assert property (
    seq_state == tms_pkg::ST_LOAD |-> en_pick_reg)
    else $error("disabled key scheduled");
  a_scan_first_key: assert property (
    s_scan_start |=> key_reg == 6'h00 && seq_state == tms_pkg::ST_LOAD)
    else $error("scan did not start at key 0");
  a_burst_serial: assert property (
    seq_state == tms_pkg::ST_BURST && !eng_done |=>
    seq_state == tms_pkg::ST_BURST && $stable(key_reg))
    else $error("burst left before completion");
  a_result_stored: assert property (
    eng_done |-> res_wr ##1 seq_state == tms_pkg::ST_FIND)
    else $error("conversion result not processed");
  a_alert_on_change: assert property (
    key_state_reg != $past(key_state_reg) |-> alert_reg)
    else $error("key change without alert");
  a_scan_wrap: assert property (
    seq_state == tms_pkg::ST_FIND && run_reg && any_en &&
    next_key <= key_reg |=> scan_count_reg == $past(scan_count_reg) + 8'h01)
    else $error("wrap did not count a new scan");
endmodule

// ==== tms_pkg.sv ====
package tms_pkg;
  // Matrix geometry and key capacity
  localparam int NUM_X = 8;
  localparam int NUM_Y = 6;
  localparam int NUM_KEYS = 48;
  localparam int CAP_SMALL = 32;
  localparam int CAP_LARGE = 48;
  localparam int DEF_Y_LINES = 4;
  localparam logic [5:0] LAST_KEY = 6'h2F;
  // Register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_THRESH = 12'h008;
  localparam logic [11:0] ADDR_KEYS_LO = 12'h00C;
  localparam logic [11:0] ADDR_KEYS_HI = 12'h010;
  localparam logic [11:0] ADDR_ERROR = 12'h014;
  localparam logic [3:0] PAGE_SETUP = 4'h1;
  localparam logic [3:0] PAGE_RESULT = 4'h2;
  // Field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int ST_CNT_LSB = 0;
  localparam int ST_KEY_LSB = 8;
  localparam int ST_ALERT_BIT = 16;
  localparam int ST_SCAN_LSB = 24;
  localparam int ERR_CAP_BIT = 0;
  localparam int ERR_CONV_BIT = 1;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Timing: acquisition pulse period at a 40 ns clock
  localparam int CLK_PERIOD_NS = 40;
  localparam int PULSE_PERIOD_NS = 1000;
  localparam int PULSE_CYC = PULSE_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [11:0] CONV_MAX = 12'hFFF;
  // Reset values
  localparam logic [3:0] DEF_DETECT = 4'h2;
  localparam logic [7:0] DEF_BURST = 8'h40;
  localparam logic [11:0] DEF_THRESH = 12'h100;
  // Per-key setup word and per-key result word
  typedef struct packed {
    logic [3:0] detect;
    logic [7:0] burst;
  } tms_setting_t;
  typedef struct packed {
    logic [3:0] integ;
    logic [11:0] signal;
  } tms_result_t;
  // Sequencer and engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FIND = 3'b001,
    ST_LOAD = 3'b010,
    ST_START = 3'b011,
    ST_BURST = 3'b100
  } tms_state_t;
  typedef enum logic [1:0] {
    EN_IDLE = 2'b00,
    EN_HI = 2'b01,
    EN_LO = 2'b10,
    EN_RAMP = 2'b11
  } tms_eng_t;
endpackage

// ==== tms_key_mem.sv ====
`timescale 1ns/10ps
// Per-key word store, registered read, reset to a default set
module tms_key_mem #(
  parameter int W = 12,
  parameter logic [W-1:0] DEF_WORD = '0,
  parameter int DEF_COUNT = 0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [5:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic [5:0] rd_addr,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem_reg [tms_pkg::NUM_KEYS];

  // One entry per key, each with its own reset value
  for (genvar i = 0; i < tms_pkg::NUM_KEYS; i++) begin : g_ent
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        mem_reg[i] <= (i < DEF_COUNT) ? DEF_WORD : '0;
      end else if (wr_en && wr_addr == 6'(i)) begin
        mem_reg[i] <= wr_data;
      end
    end
  end

  // Registered read; out-of-range index reads zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_data <= '0;
    end else if (rd_addr <= tms_pkg::LAST_KEY) begin
      rd_data <= mem_reg[rd_addr];
    end else begin
      rd_data <= '0;
    end
  end
endmodule

// ==== tms_burst_engine.sv ====
`timescale 1ns/10ps
// One key: burst of drive pulses, then single-slope conversion
module tms_burst_engine (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic [7:0] burst_len,
  input wire logic pulse_tick,
  input wire logic cmp_sync,
  output logic drive_reg,
  output logic ramp_reg,
  output logic done_reg,
  output logic [11:0] value_reg,
  output logic timeout_reg
);
  tms_pkg::tms_eng_t st_reg;
  logic [8:0] pulse_cnt_reg;

  // Pulse and ramp sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= tms_pkg::EN_IDLE;
      pulse_cnt_reg <= 9'h000;
      drive_reg <= 1'b0;
      ramp_reg <= 1'b0;
      done_reg <= 1'b0;
      value_reg <= 12'h000;
      timeout_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      unique case (st_reg)
        tms_pkg::EN_IDLE: begin
          if (start) begin
            pulse_cnt_reg <= 9'h000;
            st_reg <= tms_pkg::EN_HI;
          end
        end
        // Rising edge of a drive pulse on the next tick
        tms_pkg::EN_HI: begin
          if (pulse_tick) begin
            drive_reg <= 1'b1;
            pulse_cnt_reg <= pulse_cnt_reg + 9'h001;
            st_reg <= tms_pkg::EN_LO;
          end
        end
        // Falling edge; burst ends after burst_len pulses (min one)
        tms_pkg::EN_LO: begin
          if (pulse_tick) begin
            drive_reg <= 1'b0;
            if (pulse_cnt_reg >= {1'b0, burst_len}) begin
              value_reg <= 12'h000;
              ramp_reg <= 1'b1;
              st_reg <= tms_pkg::EN_RAMP;
            end else begin
              st_reg <= tms_pkg::EN_HI;
            end
          end
        end
        // Count until the comparator trips or the count saturates
        tms_pkg::EN_RAMP: begin
          if (cmp_sync || value_reg == tms_pkg::CONV_MAX) begin
            ramp_reg <= 1'b0;
            done_reg <= 1'b1;
            timeout_reg <= !cmp_sync;
            st_reg <= tms_pkg::EN_IDLE;
          end else begin
            value_reg <= value_reg + 12'h001;
          end
        end
      endcase
    end
  end
endmodule

// ==== tms_cmp_model.sv ====
`timescale 1ns/10ps
// Comparator stand-in: the ramp crosses a set count after it starts
module tms_cmp_model (
  input wire logic aclk,
  input wire logic ramp_en,
  input wire logic [7:0] delay,
  output logic cmp
);
  logic [7:0] cnt_reg; // Cycles since ramp start
  // Count while the ramp runs, rest at zero
  always_ff @(posedge aclk) begin
    cnt_reg <= ramp_en ? cnt_reg + 8'h01 : 8'h00;
  end
  // Low while idle, so no stale crossing is seen
  assign cmp = ramp_en && (cnt_reg >= delay);
endmodule

// ==== tb_touch_matrix_scan_sequencer.sv ====
`timescale 1ns/10ps
// Bench: setup, capacity, scan order and results over AXI
module tb_touch_matrix_scan_sequencer;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd;
  logic awr, wr_, bv, arr, rv, cmp, ramp, alert, xq = 0, rq = 0;
  logic [1:0] br, rr, resp;
  logic [7:0] xd, dly = 8'h10, b[2];
  logic [5:0] ys, keys[4];
  logic [7:0] pul[4];
  int bad_count = 0, checks = 0, cyc = 0, nk = 0, np = 0, xl = 0;
  integer seed = 32'h8E677592;
  tms_scan_seq #(.KEY_CAP(32)) tms_scan_seq_inst (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .cmp_in(cmp), .x_drive_reg(xd), .y_sel_reg(ys), .ramp_en_reg(ramp),
    .alert_reg(alert));
  tms_cmp_model tms_cmp_model_inst (.aclk(aclk), .ramp_en(ramp),
    .delay(dly), .cmp(cmp));
  // Clock at 40 ns
  always #20 aclk = ~aclk;
  // Index of a one-hot line
  function automatic int oh(input logic [7:0] v);
    oh = 0;
    for (int i = 0; i < 8; i++) if (v[i]) oh = i;
  endfunction
  // Log the first four bursts: key index and pulse count
  always @(posedge aclk) begin
    if (xd != 8'h00 && !xq) begin
      np++;
      xl = oh(xd);
    end
    if (ramp && !rq && nk < 4) begin
      keys[nk] = 6'(8 * oh({2'h0, ys}) + xl);
      pul[nk] = 8'(np);
      nk++;
      np = 0;
    end
    xq = |xd;
    rq = ramp;
  end
  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      results();
    end
  end
  // Expected schedule: key 0 on its default setup, then keys 9 and 32
  function automatic logic [31:0] exp_key(input int i);
    exp_key = (i % 3 == 0) ? 32'd0 : (i % 3 == 1) ? 32'd9 : 32'd32;
  endfunction
  // Expected pulse count of the i-th logged burst
  function automatic logic [7:0] exp_len(input int i);
    exp_len = (i % 3 == 0) ? tms_pkg::DEF_BURST : b[i % 3 - 1];
  endfunction
  task automatic chk(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Write: both channels offered, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 0;
      if (wr_) wv <= 0;
    end while (!bv);
    resp = br;
    bry <= 0;
    @(posedge aclk);
  endtask
  // Read: address held until taken, rready until data
  task automatic rdw(input logic [11:0] a, output logic [31:0] d);
    ara <= a;
    arv <= 1;
    rry <= 1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 0;
    end while (!rv);
    d = rd;
    resp = rr;
    rry <= 0;
    @(posedge aclk);
  endtask
  task automatic results();
    if (bad_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    logic [31:0] v;
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rdw(12'h004, v);
    chk("count", 32'd32, {25'h0, v[6:0]});
    rdw(12'h1A0, v);
    chk("key40", 32'h0, {31'h0, v[0]});
    wr(12'h180, 32'h240);
    chk("refuse", 32'h2, {30'h0, resp});
    // Key 0 keeps its default setup; the other defaults are disabled
    for (int k = 1; k < 32; k++) wr(12'(12'h100 + 4 * k), 32'h0);
    for (int i = 0; i < 2; i++) b[i] = 8'(($random(seed) & 3) + 1);
    dly <= 8'(($random(seed) & 8'h1F) + 8);
    wr(12'h124, {20'h0, 4'h2, b[0]});
    wr(12'h180, {20'h0, 4'h2, b[1]});
    chk("enable", 32'h0, {30'h0, resp});
    rdw(12'h004, v);
    chk("paring", 32'd3, {25'h0, v[6:0]});
    rdw(12'hFFC, v);
    chk("unmapped", 32'h3, {30'h0, resp});
    wr(12'h000, 32'h1);
    while (nk < 4) @(posedge aclk);
    for (int i = 0; i < 4; i++) begin
      chk("key", exp_key(i), {26'h0, keys[i]});
      chk("pulses", {24'h0, exp_len(i)}, {24'h0, pul[i]});
    end
    // Second bursts of keys 9 and 32 finish well inside this wait
    repeat (1000) @(posedge aclk);
    chk("alert", 32'h1, {31'h0, alert});
    rdw(12'h00C, v);
    chk("touch_lo", 32'h201, v);
    rdw(12'h010, v);
    chk("touch_hi", 32'h1, v);
    rdw(12'h224, v);
    chk("integ", 32'h2, {28'h0, v[15:12]});
    rdw(12'h014, v);
    chk("error", 32'h1, v);
    wr(12'h014, 32'h1);
    rdw(12'h014, v);
    chk("err_clr", 32'h0, v);
    rdw(12'h004, v);
    chk("alert_bit", 32'h1, {31'h0, v[16]});
    chk("alert_clr", 32'h0, {31'h0, alert});
    results();
  end
endmodule
